//--- bench/ppm_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Keypad and board model
module ppm_far_side
  import ppm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic key_pulldown_en,
  input wire logic [3:0] keys,
  input wire logic [3:0] board,
  input wire logic [3:0] lat_out,
  input wire logic [3:0] lat_oe,
  input wire logic [3:0] pd_out,
  input wire logic [3:0] pd_oe,
  output logic [3:0] key_in_port,
  output logic [3:0] lat_in,
  output logic [3:0] pd_in
);
  logic [3:0] flt_r = 4'h5;
  logic [3:0] flt_nxt;
  // Open lines wander every cycle
  always_comb begin
    flt_nxt = ~flt_r;
  end
  always_ff @(posedge ref_clk) begin
    flt_r <= flt_nxt;
  end
  // Pressed keys pull high, open keys float unless pulled down
  assign key_in_port = keys | (key_pulldown_en ? 4'h0 : flt_r & ~keys);
  // Wire level from both drivers
  assign lat_in = (lat_out & lat_oe) | (board & ~lat_oe);
  assign pd_in = (pd_out & pd_oe) | (board & ~pd_oe);
endmodule
`default_nettype wire

//--- bench/ppm_port_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defs.svh"
// ==========
// Pin rule checker
module ppm_port_props
  import ppm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reset_n_pin,
  input wire logic battery_retention_mode,
  input wire logic irq_pin,
  input wire logic [2:0] ins_code,
  input wire logic [3:0] ins_data,
  input wire logic [3:0] unbal_out_port1,
  input wire logic [3:0] unbal_out_port1_oe,
  input wire logic [3:0] cmos_out_port_oe,
  input wire logic [3:0] latched_bidir_port_out,
  input wire logic [3:0] latched_bidir_port_oe,
  input wire logic [3:0] pin_dir_bidir_port_oe,
  input wire logic [3:0] open_drain_port_oe,
  input wire logic [1:0] lcd_common_a,
  input wire logic [1:0] lcd_common_a_mid,
  input wire logic irq_req,
  input wire logic core_run
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Core running with reset pin and battery_retention_mode idle
  sequence s_live;
    (core_run && reset_n_pin && !battery_retention_mode)[*4];
  endsequence
  // Reset pin held low well past the filter
  sequence s_rst;
    (!reset_n_pin && !battery_retention_mode)[*8] ##1
    (!reset_n_pin && !battery_retention_mode)[*6];
  endsequence
  property p_dir(logic [2:0] c, logic sel);
    logic [3:0] d;
    (s_live ##0 (ins_code == c, d = ins_data)) |-> ##[2:3]
    (sel ? pin_dir_bidir_port_oe == d
         : (latched_bidir_port_oe == 4'hF && latched_bidir_port_out == d));
  endproperty
  a_rst_drive_low: assert property (s_rst |->
    unbal_out_port1 == 4'h0 && unbal_out_port1_oe == 4'hF && cmos_out_port_oe == 4'hF)
    else $error("output ports not driven low in reset");
  a_rst_bidir_in: assert property (s_rst |->
    latched_bidir_port_oe == 4'h0 && pin_dir_bidir_port_oe == 4'h0 && open_drain_port_oe == 4'h0)
    else $error("bidir or open drain driving in reset");
  a_bkp_float: assert property (battery_retention_mode[*5] |->
    unbal_out_port1_oe == 4'h0 && cmos_out_port_oe == 4'h0)
    else $error("output ports driving in battery_retention_mode");
  a_bkp_bidir_off: assert property (battery_retention_mode[*5] |->
    latched_bidir_port_oe == 4'h0 && pin_dir_bidir_port_oe == 4'h0 && open_drain_port_oe == 4'h0)
    else $error("bidir or open drain driving in battery_retention_mode");
  a_bkp_common_low: assert property (battery_retention_mode[*5] |->
    lcd_common_a == 2'h0 && lcd_common_a_mid == 2'h0)
    else $error("commons not low in battery_retention_mode");
  a_common_level: assert property (lcd_common_a != 2'h3 &&
    (lcd_common_a & lcd_common_a_mid) == 2'h0)
    else $error("common levels in conflict");
  a_glitch_kept: assert property ((core_run && reset_n_pin) ##1
    (!reset_n_pin)[*5] ##1 reset_n_pin[*8] |-> core_run)
    else $error("short reset pulse stopped the core");
  a_irq_single: assert property (irq_req |=> !irq_req)
    else $error("interrupt pulse longer than one cycle");
  a_irq_quiet: assert property (irq_pin[*8] |-> !irq_req)
    else $error("interrupt without falling edge");
  a_ins_input: assert property (s_live ##0 ins_code == `PPM_INS_IN |->
    ##[2:3] latched_bidir_port_oe == 4'h0)
    else $error("input instruction left port driving");
  a_ins_output: assert property (p_dir(`PPM_INS_OUT, 1'b0))
    else $error("output instruction did not latch output");
  a_ins_config: assert property (p_dir(`PPM_INS_FPC, 1'b1))
    else $error("pin direction config not applied");
  c_irq: cover property (irq_req);
  c_glitch: cover property ((!reset_n_pin)[*5] ##1 reset_n_pin ##1 core_run);
  c_battery_retention_mode: cover property (battery_retention_mode[*5]);
endmodule
bind ppm_port_ctrl ppm_port_props i_ppm_port_props (.ref_clk(ref_clk), .nrst(nrst),
  .reset_n_pin(reset_n_pin), .battery_retention_mode(battery_retention_mode),
  .irq_pin(irq_pin), .ins_code(ins_code), .ins_data(ins_data),
  .unbal_out_port1(unbal_out_port1), .unbal_out_port1_oe(unbal_out_port1_oe),
  .cmos_out_port_oe(cmos_out_port_oe), .latched_bidir_port_out(latched_bidir_port_out),
  .latched_bidir_port_oe(latched_bidir_port_oe), .pin_dir_bidir_port_oe(pin_dir_bidir_port_oe),
  .open_drain_port_oe(open_drain_port_oe), .lcd_common_a(lcd_common_a),
  .lcd_common_a_mid(lcd_common_a_mid),
  .irq_req(irq_req), .core_run(core_run));
`default_nettype wire

//--- bench/ppm_port_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defs.svh"
// ==========
// Top level bench
module ppm_port_ctrl_test
  import ppm_pkg::*;
;
  logic ref_clk, nrst, reset_n_pin, battery_retention_mode, irq_pin, hold_pin;
  logic outage_sense_pin, adc_cmp, avs_read, avs_write, avs_waitrequest, key_pulldown_en;
  logic irq_req, hold_mode, core_run, adc_dac_out, watchdog_option;
  logic [1:0] dac_bits, lcd_common_a, lcd_common_a_mid, cycle_time_sel;
  logic [9:0] upper_segment;
  logic [2:0] ins_code;
  logic [3:0] gen_in_port, keys, board, avs_address, ins_data, key_in_port, lat_in, pd_in;
  logic [3:0] unbal_out_port1, unbal_out_port1_oe, cmos_out_port, cmos_out_port_oe;
  logic [3:0] unbal_out_port2, latched_bidir_port_out, latched_bidir_port_oe;
  logic [3:0] pin_dir_bidir_port_out, pin_dir_bidir_port_oe, open_drain_port_oe;
  logic [3:0] shared_port_segment, unbal_out_port2_oe;
  logic [31:0] avs_writedata, avs_readdata, x, q, wd;
  int err_count, num_checks, cyc, irqs, n, t0;
  ppm_port_ctrl #(.OPT_LOAD_CYC(20), .CONV_CYC(60), .LCD_HALF_CYC(40), .OPT_GEN_SEG(1'b1))
  i_ppm_port_ctrl (.latched_bidir_port_in(lat_in), .pin_dir_bidir_port_in(pd_in), .*);
  ppm_far_side i_ppm_far_side (.ref_clk(ref_clk), .key_pulldown_en(key_pulldown_en),
    .keys(keys), .board(board), .lat_out(latched_bidir_port_out),
    .lat_oe(latched_bidir_port_oe), .pd_out(pin_dir_bidir_port_out),
    .pd_oe(pin_dir_bidir_port_oe), .key_in_port(key_in_port), .lat_in(lat_in), .pd_in(pd_in));
  // Clock generator
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ==========
  // Helpers
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [3:0] odx(input logic [3:0] od, input logic [1:0] dac);
    return ~od & ~{dac, 2'h0};
  endfunction
  function automatic logic [15:0] prt(input logic [31:0] w);
    return {w[11:8], w[7:4], w[3:0] & ~w[19:16], w[3:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ins(input logic [2:0] c, input logic [3:0] d);
    ins_code <= c;
    ins_data <= d;
    @(posedge ref_clk);
    ins_code <= `PPM_INS_NONE;
    step(3);
  endtask
  task automatic boot();
    n = 0;
    while (core_run !== 1'b1 && n < 100) begin
      chk(key_pulldown_en, 0);
      @(posedge ref_clk);
      n++;
    end
    chk(n >= 20 && n < 100, 1);
    step(2);
    chk(key_pulldown_en, 1);
    chk({cycle_time_sel, watchdog_option}, 3'h0);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Interrupt counter and run limit
  always @(posedge ref_clk) begin
    cyc++;
    if (irq_req === 1'b1) irqs++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  // ==========
  // Main sequence
  initial begin
    x = 32'd27;
    {nrst, reset_n_pin, battery_retention_mode, avs_read, avs_write, adc_cmp} = 6'h0;
    {irq_pin, hold_pin, outage_sense_pin} = 3'h7;
    {gen_in_port, keys, board, avs_address, ins_data, dac_bits, ins_code} = 25'h0;
    avs_writedata = 32'h0;
    step(12);
    nrst <= 1'b1;
    step(20);
    reset_n_pin <= 1'b1;
    boot();
    bus(0, `PPM_REG_CTRL, 0, q);
    chk(q, 32'h4);
    bus(0, `PPM_REG_STAT, 0, q);
    chk(q & 32'hF, 32'hA);
    bus(1, 4'h2, 32'hFFFFFFFF, q);
    bus(0, 4'h2, 0, q);
    chk(q, 0);
    for (int i = 0; i < 8; i++) begin
      wd = rnd();
      dac_bits <= wd[25:24];
      bus(1, `PPM_REG_PORTS, wd, q);
      bus(1, `PPM_REG_CTRL, {28'h0, wd[28], 3'h0}, q);
      step(2);
      chk({unbal_out_port2, unbal_out_port1, cmos_out_port}, {wd[23:16], wd[3:0]});
      chk(upper_segment, {2'h0, wd[15:8]});
      chk(open_drain_port_oe, odx(wd[7:4], wd[25:24]));
      chk(shared_port_segment, wd[28] ? wd[11:8] : wd[15:12]);
    end
    for (int i = 0; i < 6; i++) begin
      wd = rnd();
      {gen_in_port, keys, board} <= wd[11:0];
      ins(`PPM_INS_OUT, wd[15:12]);
      chk({latched_bidir_port_oe, latched_bidir_port_out}, {4'hF, wd[15:12]});
      ins(`PPM_INS_FPC, wd[19:16]);
      chk(pin_dir_bidir_port_oe, wd[19:16]);
      ins(`PPM_INS_IN, 4'h0);
      chk(latched_bidir_port_oe, 0);
      bus(0, `PPM_REG_PORTS, 0, q);
      chk(q[15:0], prt(wd));
    end
    bus(1, `PPM_REG_CTRL, 32'h5, q);
    irqs = 0;
    for (int i = 0; i < 2; i++) begin
      irq_pin <= 1'b0;
      step(4);
      irq_pin <= 1'b1;
      step(10);
      chk(irqs, 1);
      bus(1, `PPM_REG_CTRL, 32'h4, q);
    end
    bus(1, `PPM_REG_CTRL, 32'h6, q);
    hold_pin <= 1'b0;
    step(8);
    chk(hold_mode, 1);
    bus(1, `PPM_REG_CTRL, 32'h4, q);
    step(8);
    chk(hold_mode, 0);
    hold_pin <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      adc_cmp <= k[0];
      bus(1, `PPM_REG_CTRL, 32'h14, q);
      t0 = cyc;
      q = 32'h20;
      while (q[5] !== 1'b0 && cyc - t0 < 200) bus(0, `PPM_REG_STAT, 0, q);
      chk(cyc - t0 >= 56 && cyc - t0 <= 72, 1);
      bus(0, `PPM_REG_ADC, 0, q);
      chk(q[5:0], k ? `PPM_ADC_FULL : 6'h0);
      chk(adc_dac_out, k[0]);
    end
    reset_n_pin <= 1'b0;
    step(5);
    reset_n_pin <= 1'b1;
    step(10);
    chk(core_run, 1);
    battery_retention_mode <= 1'b1;
    step(6);
    bus(0, `PPM_REG_PORTS, 0, q);
    chk(q[15:8], 0);
    chk({unbal_out_port1_oe, unbal_out_port2_oe, cmos_out_port_oe}, 0);
    chk({shared_port_segment, upper_segment}, 0);
    battery_retention_mode <= 1'b0;
    step(6);
    reset_n_pin <= 1'b0;
    step(20);
    chk({unbal_out_port1, unbal_out_port1_oe, latched_bidir_port_oe}, 12'h0F0);
    chk(core_run, 0);
    reset_n_pin <= 1'b1;
    boot();
    wrap_up();
  end
endmodule
`default_nettype wire

//--- core/ppm_port_ctrl.sv
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defs.svh"
// Function
// - Key-port pull-downs switch all four pins together.
// - Battery_retention_mode mode blocks key port and general input port reads.
// - Unbalanced and CMOS output ports float in battery_retention_mode mode.
// - Unbalanced and CMOS output ports drive low during reset.
// - Read or pin-test instruction latches bidirectional port as input.
// - Write, bit-set or bit-reset latches bidirectional port as output.
// - Both bidirectional ports return to input during reset.
// - Battery_retention_mode mode: bidirectional ports input with input path off.
// - Second bidirectional port direction set per pin by config instruction.
// - Open-drain port floats in reset and battery_retention_mode; bits 2,3 carry DAC.
// - Status set/reset switch four shared pins LCD or CMOS together when the general-use option is set.
// - Shared pins select LCD segment-off at reset, low in battery_retention_mode.
// - General option: shared pins show port register or output latch.
// - LCD drive at 100 Hz frame, half duty, half bias.
// - Upper segment group may be general outputs by option.
// - Commons keep normal waveform in reset, low in battery_retention_mode.
// - Six-bit successive approximation over 1.28 ms, 3FH full scale.
// - Falling edge on interrupt pin raises irq when enabled.
// - Hold mode when hold enable set and hold pin low.
// - Reset begins after six consecutive low samples.
// - Options load over about 1 ms, then execution starts at 0.
// - Options: watchdog, pull-downs, cycle time, LCD or general use.
module ppm_port_ctrl
  import ppm_pkg::*;
#(
  parameter int OPT_LOAD_CYC = (`PPM_OPT_LOAD_US * (`PPM_CLK_KHZ / 1000)),
  parameter int CONV_CYC = (`PPM_CONV_TIME_US * (`PPM_CLK_KHZ / 1000)),
  parameter int LCD_HALF_CYC = (`PPM_CLK_KHZ * 1000) / (`PPM_FRAME_HZ * 2),
  parameter logic [1:0] OPT_CYCLE_TIME = 2'h0,
  parameter logic OPT_WATCHDOG = 1'b0,
  parameter logic OPT_PULLDOWN = 1'b1,
  parameter logic OPT_GEN_SEG = 1'b0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reset_n_pin,
  input wire logic battery_retention_mode,
  input wire logic irq_pin,
  input wire logic hold_pin,
  input wire logic outage_sense_pin,
  input wire logic [3:0] key_in_port,
  input wire logic [3:0] gen_in_port,
  input wire logic [3:0] latched_bidir_port_in,
  input wire logic [3:0] pin_dir_bidir_port_in,
  input wire logic adc_cmp,
  input wire logic [1:0] dac_bits,
  input wire logic [2:0] ins_code,
  input wire logic [3:0] ins_data,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic key_pulldown_en,
  output logic [3:0] unbal_out_port1,
  output logic [3:0] unbal_out_port1_oe,
  output logic [3:0] unbal_out_port2,
  output logic [3:0] unbal_out_port2_oe,
  output logic [3:0] cmos_out_port,
  output logic [3:0] cmos_out_port_oe,
  output logic [3:0] latched_bidir_port_out,
  output logic [3:0] latched_bidir_port_oe,
  output logic [3:0] pin_dir_bidir_port_out,
  output logic [3:0] pin_dir_bidir_port_oe,
  output logic [3:0] open_drain_port_oe,
  output logic [3:0] shared_port_segment,
  output logic [9:0] upper_segment,
  output logic [1:0] lcd_common_a,
  output logic [1:0] lcd_common_a_mid,
  output logic adc_dac_out,
  output logic irq_req,
  output logic hold_mode,
  output logic core_run,
  output logic [1:0] cycle_time_sel,
  output logic watchdog_option
);

  // ==========================================
  // Input synchronisers
  logic [1:0] rst_s_r, irq_s_r, bkp_s_r, hold_s_r, sns_s_r;
  logic [3:0] key_s1_r, key_s2_r, gen_s1_r, gen_s2_r;
  logic [3:0] lb_s1_r, lb_s2_r, pd_s1_r, pd_s2_r;
  logic [1:0] adc_s_r;
  logic irq_d_r;

  // Two-flop capture of every pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s_r <= 2'h0; // Held in reset until pin seen high
      irq_s_r <= 2'h3;
      irq_d_r <= 1'b1;
      bkp_s_r <= 2'h0;
      hold_s_r <= 2'h3;
      sns_s_r <= 2'h0;
      adc_s_r <= 2'h0;
      key_s1_r <= 4'h0;
      key_s2_r <= 4'h0;
      gen_s1_r <= 4'h0;
      gen_s2_r <= 4'h0;
      lb_s1_r <= 4'h0;
      lb_s2_r <= 4'h0;
      pd_s1_r <= 4'h0;
      pd_s2_r <= 4'h0;
    end else begin
      rst_s_r <= {rst_s_r[0], reset_n_pin};
      irq_s_r <= {irq_s_r[0], irq_pin};
      irq_d_r <= irq_s_r[1];
      bkp_s_r <= {bkp_s_r[0], battery_retention_mode};
      hold_s_r <= {hold_s_r[0], hold_pin};
      sns_s_r <= {sns_s_r[0], outage_sense_pin};
      adc_s_r <= {adc_s_r[0], adc_cmp};
      key_s1_r <= key_in_port;
      key_s2_r <= key_s1_r;
      gen_s1_r <= gen_in_port;
      gen_s2_r <= gen_s1_r;
      lb_s1_r <= latched_bidir_port_in;
      lb_s2_r <= lb_s1_r;
      pd_s1_r <= pin_dir_bidir_port_in;
      pd_s2_r <= pd_s1_r;
    end
  end

  wire logic bkp = bkp_s_r[1];

  // ==========================================
  // Reset filter and start-up phase
  ppm_phase_t phase_r, phase_nxt;
  logic [2:0] low_cnt_r, low_cnt_nxt;
  logic [31:0] opt_cnt_r, opt_cnt_nxt;
  logic in_rst;

  // Low count, option load timer
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    phase_nxt = phase_r;
    opt_cnt_nxt = opt_cnt_r;
    if (rst_s_r[1]) begin
      low_cnt_nxt = 3'h0;
    end else if (low_cnt_r != 3'(`PPM_RST_LOW_CYC)) begin
      low_cnt_nxt = low_cnt_r + 3'h1;
    end
    case (phase_r)
      PPM_RST: begin
        opt_cnt_nxt = 32'h0;
        if (rst_s_r[1]) begin
          phase_nxt = PPM_OPT;
        end
      end
      PPM_OPT: begin
        opt_cnt_nxt = opt_cnt_r + 32'h1;
        if (opt_cnt_r == 32'(OPT_LOAD_CYC - 1)) begin
          phase_nxt = PPM_RUN;
        end
      end
      PPM_RUN: begin
      end
      default: phase_nxt = PPM_RST;
    endcase
    if (low_cnt_nxt == 3'(`PPM_RST_LOW_CYC)) begin
      phase_nxt = PPM_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r <= 3'h0;
      phase_r <= PPM_RST;
      opt_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      phase_r <= phase_nxt;
      opt_cnt_r <= opt_cnt_nxt;
    end
  end

  assign in_rst = (phase_r == PPM_RST);
  wire logic opt_ok = (phase_r == PPM_RUN);

  // ==========================================
  // Software registers and port state
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [3:0] b1_r, b1_nxt, b2_r, b2_nxt, d_r, d_nxt, h_r, h_nxt;
  logic [3:0] e_r, e_nxt, f_r, f_nxt, fdir_r, fdir_nxt;
  logic [3:0] shared_port_reg_r, shared_port_reg_nxt, glatch_r, glatch_nxt;
  logic e_out_r, e_out_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic ack_r, ack_nxt;
  logic [5:0] adc_res_r;
  logic adc_busy;

  // Write decode, instruction decode, read mux
  always_comb begin
    ctrl_nxt = ctrl_r;
    {b1_nxt, b2_nxt, d_nxt, h_nxt} = {b1_r, b2_r, d_r, h_r};
    {e_nxt, f_nxt, fdir_nxt} = {e_r, f_r, fdir_r};
    {shared_port_reg_nxt, glatch_nxt} = {shared_port_reg_r, glatch_r};
    e_out_nxt = e_out_r;
    rd_nxt = rd_r;
    ack_nxt = 1'b0;
    ctrl_nxt[`PPM_CTL_ADCGO] = 1'b0;
    if ((avs_read || avs_write) && !ack_r) begin
      ack_nxt = 1'b1;
      rd_nxt = 32'h0;
      if (avs_write) begin
        case (avs_address)
          `PPM_REG_CTRL: ctrl_nxt = avs_writedata[4:0];
          `PPM_REG_PORTS: begin
            {glatch_nxt, shared_port_reg_nxt, h_nxt, d_nxt} = avs_writedata[15:0];
            {b2_nxt, b1_nxt} = avs_writedata[23:16];
          end
          default: ;
        endcase
      end else begin
        case (avs_address)
          `PPM_REG_CTRL: rd_nxt = {27'h0, ctrl_r};
          `PPM_REG_PORTS: rd_nxt = {16'h0, bkp ? 4'h0 : gen_s2_r, bkp ? 4'h0 : key_s2_r,
                                    bkp ? 4'h0 : pd_s2_r, bkp ? 4'h0 : lb_s2_r};
          `PPM_REG_STAT: rd_nxt = {26'h0, adc_busy, hold_mode, sns_s_r[1], bkp,
                                   opt_ok, in_rst};
          `PPM_REG_ADC: rd_nxt = {26'h0, adc_res_r};
          default: rd_nxt = 32'h0;
        endcase
      end
    end
    case (ins_code)
      `PPM_INS_IN: e_out_nxt = 1'b0;
      `PPM_INS_OUT: begin
        e_out_nxt = 1'b1;
        e_nxt = ins_data;
      end
      `PPM_INS_FPC: fdir_nxt = ins_data;
      default: ;
    endcase
    if (in_rst) begin
      e_out_nxt = 1'b0;
      fdir_nxt = 4'h0;
      ctrl_nxt[`PPM_CTL_LCDSEL] = 1'b1;
      ctrl_nxt[`PPM_CTL_IRQEN] = 1'b0;
      ctrl_nxt[`PPM_CTL_HOLD_ENABLE_FLAG] = 1'b0;
    end
    f_nxt = f_r;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= 5'h04;
      {b1_r, b2_r, d_r, h_r} <= 16'h0;
      {e_r, f_r, fdir_r} <= 12'h0;
      {shared_port_reg_r, glatch_r} <= 8'h0;
      e_out_r <= 1'b0;
      rd_r <= 32'h0;
      ack_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      {b1_r, b2_r, d_r, h_r} <= {b1_nxt, b2_nxt, d_nxt, h_nxt};
      {e_r, f_r, fdir_r} <= {e_nxt, f_nxt, fdir_nxt};
      {shared_port_reg_r, glatch_r} <= {shared_port_reg_nxt, glatch_nxt};
      e_out_r <= e_out_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
    end
  end

  // ==========================================
  // LCD timing: 100 Hz frame, two commons
  logic [31:0] lcd_cnt_r, lcd_cnt_nxt;
  logic [1:0] lcd_ph_r, lcd_ph_nxt;

  always_comb begin
    lcd_cnt_nxt = lcd_cnt_r + 32'h1;
    lcd_ph_nxt = lcd_ph_r;
    if (lcd_cnt_r == 32'(LCD_HALF_CYC / 2 - 1)) begin
      lcd_cnt_nxt = 32'h0;
      lcd_ph_nxt = lcd_ph_r + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lcd_cnt_r <= 32'h0;
      lcd_ph_r <= 2'h0;
    end else begin
      lcd_cnt_r <= lcd_cnt_nxt;
      lcd_ph_r <= lcd_ph_nxt;
    end
  end

  // ==========================================
  // Six-bit successive approximation converter
  ppm_adc_t adc_st_r, adc_st_nxt;
  logic [5:0] adc_res_nxt, adc_trial_r, adc_trial_nxt;
  logic [2:0] adc_bit_r, adc_bit_nxt;
  logic [31:0] adc_cnt_r, adc_cnt_nxt;

  // one bit per sixth of conversion
  always_comb begin
    adc_st_nxt = adc_st_r;
    adc_res_nxt = adc_res_r;
    adc_trial_nxt = adc_trial_r;
    adc_bit_nxt = adc_bit_r;
    adc_cnt_nxt = adc_cnt_r;
    case (adc_st_r)
      PPM_AIDLE: begin
        if (ctrl_r[`PPM_CTL_ADCGO]) begin
          adc_st_nxt = PPM_ACONV;
          adc_bit_nxt = 3'(`PPM_ADC_MSB);
          adc_trial_nxt = 6'h20;
          adc_cnt_nxt = 32'h0;
        end
      end
      PPM_ACONV: begin
        adc_cnt_nxt = adc_cnt_r + 32'h1;
        if (adc_cnt_r == 32'(CONV_CYC / 6 - 1)) begin
          adc_cnt_nxt = 32'h0;
          if (!adc_s_r[1]) begin
            adc_trial_nxt[adc_bit_r] = 1'b0;
          end
          if (adc_bit_r == 3'h0) begin
            adc_res_nxt = adc_trial_nxt & `PPM_ADC_FULL;
            adc_st_nxt = PPM_AIDLE;
          end else begin
            adc_bit_nxt = adc_bit_r - 3'h1;
            adc_trial_nxt[adc_bit_r - 3'h1] = 1'b1;
          end
        end
      end
      default: adc_st_nxt = PPM_AIDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      adc_st_r <= PPM_AIDLE;
      adc_res_r <= 6'h0;
      adc_trial_r <= 6'h0;
      adc_bit_r <= 3'h0;
      adc_cnt_r <= 32'h0;
    end else begin
      adc_st_r <= adc_st_nxt;
      adc_res_r <= adc_res_nxt;
      adc_trial_r <= adc_trial_nxt;
      adc_bit_r <= adc_bit_nxt;
      adc_cnt_r <= adc_cnt_nxt;
    end
  end

  assign adc_busy = (adc_st_r == PPM_ACONV);

  // ==========================================
  // Registered pin outputs
  logic [3:0] shared_nxt;
  logic [1:0] com_nxt, mid_nxt;
  logic lcd_mode;
  always_comb begin
    lcd_mode = ctrl_r[`PPM_CTL_LCDSEL] || !opt_ok || !OPT_GEN_SEG;
    // half duty: active common drives high while the other is low; both sit mid in even phases
    com_nxt = {lcd_ph_r == 2'h3, lcd_ph_r == 2'h1};
    mid_nxt = {!lcd_ph_r[0], !lcd_ph_r[0]};
    shared_nxt = {4{lcd_ph_r[1]}};
    if (!lcd_mode) begin
      shared_nxt = ctrl_r[`PPM_CTL_PSEL] ? shared_port_reg_r : glatch_r;
    end
    if (in_rst) begin
      shared_nxt = {4{lcd_ph_r[1]}};
    end
    if (bkp) begin
      com_nxt = 2'h0;
      mid_nxt = 2'h0;
      shared_nxt = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
      key_pulldown_en <= 1'b0;
      {unbal_out_port1, unbal_out_port2, cmos_out_port} <= 12'h0;
      {unbal_out_port1_oe, unbal_out_port2_oe, cmos_out_port_oe} <= 12'h0;
      {latched_bidir_port_out, latched_bidir_port_oe} <= 8'h0;
      {pin_dir_bidir_port_out, pin_dir_bidir_port_oe} <= 8'h0;
      open_drain_port_oe <= 4'h0;
      shared_port_segment <= 4'h0;
      upper_segment <= 10'h0;
      lcd_common_a <= 2'h0;
      lcd_common_a_mid <= 2'h0;
      adc_dac_out <= 1'b0;
      irq_req <= 1'b0;
      hold_mode <= 1'b0;
      core_run <= 1'b0;
      cycle_time_sel <= 2'h0;
      watchdog_option <= 1'b0;
    end else begin
      avs_readdata <= rd_nxt;
      avs_waitrequest <= !ack_nxt;
      key_pulldown_en <= opt_ok && OPT_PULLDOWN && !bkp;
      // low in reset, float in battery_retention_mode
      unbal_out_port1 <= in_rst ? 4'h0 : b1_r;
      unbal_out_port2 <= in_rst ? 4'h0 : b2_r;
      cmos_out_port <= in_rst ? 4'h0 : d_r;
      unbal_out_port1_oe <= {4{!bkp}};
      unbal_out_port2_oe <= {4{!bkp}};
      cmos_out_port_oe <= {4{!bkp}};
      latched_bidir_port_out <= e_r;
      latched_bidir_port_oe <= {4{e_out_r && !bkp && !in_rst}};
      pin_dir_bidir_port_out <= f_r;
      pin_dir_bidir_port_oe <= (bkp || in_rst) ? 4'h0 : fdir_r;
      // open drain released in reset and battery_retention_mode
      open_drain_port_oe <= (bkp || in_rst) ? 4'h0 : {~dac_bits & ~h_r[3:2], ~h_r[1:0]};
      shared_port_segment <= shared_nxt;
      upper_segment <= bkp ? 10'h0 : (lcd_mode ? {10{lcd_ph_r[1]}} : {2'h0, glatch_r, shared_port_reg_r});
      lcd_common_a <= com_nxt;
      lcd_common_a_mid <= mid_nxt;
      adc_dac_out <= adc_trial_r[adc_bit_r];
      // falling edge pulse, gated by enable
      irq_req <= irq_d_r && !irq_s_r[1] && ctrl_r[`PPM_CTL_IRQEN];
      hold_mode <= ctrl_r[`PPM_CTL_HOLD_ENABLE_FLAG] && !hold_s_r[1];
      // run from address 0 after options
      core_run <= opt_ok;
      cycle_time_sel <= opt_ok ? OPT_CYCLE_TIME : 2'h0;
      watchdog_option <= opt_ok && OPT_WATCHDOG;
    end
  end

endmodule
`default_nettype wire

//--- shared/ppm_defs.svh
`ifndef PPM_DEFS_SVH
`define PPM_DEFS_SVH
// Clock rate and timing
`define PPM_CLK_KHZ 100000
`define PPM_RST_LOW_CYC 6
`define PPM_CONV_TIME_US 1280
`define PPM_OPT_LOAD_US 1000
`define PPM_FRAME_HZ 100
// Converter full scale code
`define PPM_ADC_FULL 6'h3F
`define PPM_ADC_MSB 5
// Avalon register byte offsets
`define PPM_REG_CTRL 4'h0
`define PPM_REG_PORTS 4'h4
`define PPM_REG_STAT 4'h8
`define PPM_REG_ADC 4'hC
// Control register fields
`define PPM_CTL_IRQEN 0
`define PPM_CTL_HOLD_ENABLE_FLAG 1
`define PPM_CTL_LCDSEL 2
`define PPM_CTL_PSEL 3
`define PPM_CTL_ADCGO 4
// Instruction codes on ins_code
`define PPM_INS_NONE 3'h0
`define PPM_INS_IN 3'h1
`define PPM_INS_OUT 3'h2
`define PPM_INS_FPC 3'h3
`endif

//--- shared/ppm_pkg.sv
package ppm_pkg;
  typedef enum {PPM_RST, PPM_OPT, PPM_RUN} ppm_phase_t;
  typedef enum {PPM_AIDLE, PPM_ACONV} ppm_adc_t;
endpackage
